/* rtl/dds_pkg.sv */
// shared constants for the dds control core and its serial host
// assumes one 100 MHz clock shared by both ends
package dds_pkg;
    // clock and serial timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 20;
    localparam int SCLK_HALF_CYC =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // datapath widths
    localparam int WORD_W = 16;
    localparam int ACC_W = 28;
    localparam int HALF_W = 14;
    localparam int PHASE_W = 12;
    localparam int DAC_W = 10;
    localparam logic [DAC_W-1:0] DAC_MIDSCALE = 10'h200;
    localparam logic [8:0] SINE_AMPL = 9'h1FF;
    // serial word layout: two address bits on top
    localparam int WADDR_HI = 15;
    localparam int WADDR_LO = 14;
    localparam logic [1:0] WADDR_CTRL = 2'h0;
    localparam logic [1:0] WADDR_FREQ_A = 2'h1;
    localparam logic [1:0] WADDR_FREQ_B = 2'h2;
    localparam logic [1:0] WADDR_PHASE = 2'h3;
    localparam int PHASE_SEL_POS = 12;
    // control word fields
    localparam int CTRL_FREQ_SELECT_BIT_POS = 0;
    localparam int CTRL_PSEL_POS = 1;
    localparam int CTRL_PINSEL_POS = 2;
    localparam int CTRL_PDOWN_POS = 3;
    localparam int CTRL_OUTEN_POS = 4;
    localparam int CTRL_OUTSRC_POS = 5;
    localparam logic [5:0] CTRL_RESET = 6'h04;
    // host register port
    localparam logic [3:0] HOST_TX_ADDR = 4'h0;
    localparam logic [3:0] HOST_STAT_ADDR = 4'h4;
    localparam int STAT_BUSY_POS = 0;
    typedef enum logic [2:0]
    {
        DDS_IDLE,
        DDS_START,
        DDS_HIGH,
        DDS_LOW,
        DDS_END
    } dds_host_state_t;
endpackage : dds_pkg

/* rtl/dds_link_if.sv */
// three-wire serial link between host and dds core
// assumes both ends are clocked by the same clk
interface dds_link_if;
    logic serial_clock_in;
    logic serial_data_in;
    logic frame_sync_n;
    modport dev
    (
        input serial_clock_in,
        input serial_data_in,
        input frame_sync_n
    );
    modport host
    (
        output serial_clock_in,
        output serial_data_in,
        output frame_sync_n
    );
endinterface : dds_link_if

/* rtl/dds_host.sv */
// serial host: software writes a 16-bit word, the host frames it out
// assumes link pins are sampled by the device on the same clk
module dds_host
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    dds_link_if.host link
);
    import dds_pkg::*;

    dds_host_state_t state_reg, state_next;
    logic [7:0] wait_reg, wait_next;
    logic [3:0] bit_reg, bit_next;
    logic [WORD_W-1:0] shift_reg, shift_next;
    logic sclk_reg, sclk_next;
    logic frame_sync_n_reg, frame_sync_n_next;
    logic [31:0] rdata_reg, rdata_next;
    logic half_done;

    assign half_done = (wait_reg == 8'(SCLK_HALF_CYC - 1));

    // framing engine; sclk idles high so it is high at frame start
    always_comb
    begin
        state_next = state_reg;
        wait_next = half_done ? 8'h00 : wait_reg + 8'h01;
        bit_next = bit_reg;
        shift_next = shift_reg;
        sclk_next = sclk_reg;
        frame_sync_n_next = frame_sync_n_reg;
        case (state_reg)
            DDS_IDLE:
            begin
                wait_next = 8'h00;
                // a write while busy is dropped, status shows busy
                if (wr && addr == HOST_TX_ADDR)
                begin
                    shift_next = wdata[WORD_W-1:0];
                    bit_next = 4'h0;
                    frame_sync_n_next = 1'b0;
                    state_next = DDS_START;
                end
            end
            DDS_START, DDS_HIGH:
                if (half_done)
                begin
                    sclk_next = 1'b0; // falling edge, data stable
                    state_next = DDS_LOW;
                end
            DDS_LOW:
                if (half_done)
                begin
                    sclk_next = 1'b1;
                    if (bit_reg == 4'hF)
                        state_next = DDS_END; // exactly 16 bits
                    else
                    begin
                        shift_next = {shift_reg[WORD_W-2:0], 1'b0};
                        bit_next = bit_reg + 4'h1;
                        state_next = DDS_HIGH;
                    end
                end
            DDS_END:
                if (half_done)
                begin
                    frame_sync_n_next = 1'b1; // after sixteenth fall
                    state_next = DDS_IDLE;
                end
            default:
                state_next = DDS_IDLE;
        endcase
    end

    // status read, data one cycle after the strobe
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (rd && addr == HOST_STAT_ADDR)
            rdata_next[STAT_BUSY_POS] = (state_reg != DDS_IDLE);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= DDS_IDLE;
            wait_reg <= 8'h00;
            bit_reg <= 4'h0;
            shift_reg <= 16'h0000;
            sclk_reg <= 1'b1;
            frame_sync_n_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            sclk_reg <= sclk_next;
            frame_sync_n_reg <= frame_sync_n_next;
            rdata_reg <= rdata_next;
        end
    end

    assign link.serial_clock_in = sclk_reg;
    assign link.serial_data_in = shift_reg[WORD_W-1];
    assign link.frame_sync_n = frame_sync_n_reg;
    assign rdata = rdata_reg;
endmodule : dds_host

/* rtl/dds_core.sv */
// dds control core: serial word loader, phase accumulator, phase offset,
// sine lookup and logic output
// assumes link pins change synchronously to clk and sclk is slower than clk/2
// Function
// - frequency word a or b feeds accumulator
// - frequency choice from pin or control bit
// - phase offset a or b added after accumulator
// - phase choice from pin or control bit
// - datapath reset clears accumulator, output midscale
// - datapath reset keeps all loaded registers
// - powerdown pin high powers down converter
// - powerdown pin or bit, either works
// - serial words are exactly sixteen bits
// - data sampled on serial clock falling edge
// - frame sync low starts loading a word
// - logic output driven only when enabled
// - output frequency is word fraction of clock
// - accumulator adds selected word every clock
// - accumulate, offset, sine lookup, converter code
// - accumulator is twenty-eight bits wide
// - twelve-bit offset added to accumulator msbs
// - back-to-back words while frame held low
// - both bits set routes comparator out
//
// The plain strobed port and the placing of the registers were left to the implementer.
module dds_core
(
    input wire logic clk,
    input wire logic rst,
    dds_link_if.dev link,
    input wire logic freq_select_pin,
    input wire logic phase_select_pin,
    input wire logic datapath_reset,
    input wire logic dac_powerdown_pin,
    input wire logic comparator_in,
    output logic [dds_pkg::DAC_W-1:0] dac_code,
    output logic dac_powerdown,
    output logic square_out_pin,
    output logic square_out_oe_n
);
    import dds_pkg::*;

    // serial receiver state
    logic sclk_q_reg, sclk_q_next;
    logic [WORD_W-1:0] shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic word_done;
    logic [WORD_W-1:0] word;

    // host-addressable registers
    logic [ACC_W-1:0] freq_a_reg, freq_a_next;
    logic [ACC_W-1:0] freq_b_reg, freq_b_next;
    logic [PHASE_W-1:0] phase_a_reg, phase_a_next;
    logic [PHASE_W-1:0] phase_b_reg, phase_b_next;
    logic freq_a_hi_reg, freq_a_hi_next;
    logic freq_b_hi_reg, freq_b_hi_next;
    logic [5:0] ctrl_reg, ctrl_next;

    // datapath state
    logic freq_select_bit_s1_reg, freq_select_bit_s2_reg, psel_s1_reg, psel_s2_reg;
    logic [ACC_W-1:0] acc_reg, acc_next;
    logic [DAC_W-1:0] dac_reg, dac_next;
    logic pdown_reg, pdown_next;
    logic sq_reg, sq_next;
    logic sq_oe_n_reg, sq_oe_n_next;
    logic use_b_freq, use_b_phase;
    logic [PHASE_W-1:0] lut_addr;
    logic [31:0] prod;
    logic [8:0] mag;

    // bit capture on each sensed falling sclk edge inside a frame
    always_comb
    begin
        sclk_q_next = link.serial_clock_in;
        shift_next = shift_reg;
        bit_next = bit_reg;
        word_done = 1'b0;
        if (link.frame_sync_n)
            bit_next = 4'h0; // frame high aborts a partial word
        else if (sclk_q_reg && !link.serial_clock_in)
        begin
            shift_next = {shift_reg[WORD_W-2:0], link.serial_data_in};
            bit_next = bit_reg + 4'h1; // wraps, next word follows
            word_done = (bit_reg == 4'hF);
        end
    end
    assign word = shift_next;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_q_reg <= 1'b1;
            shift_reg <= 16'h0000;
            bit_reg <= 4'h0;
        end
        else
        begin
            sclk_q_reg <= sclk_q_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
        end
    end

    // word decode; frequency words load low half then high half
    always_comb
    begin
        freq_a_next = freq_a_reg;
        freq_b_next = freq_b_reg;
        phase_a_next = phase_a_reg;
        phase_b_next = phase_b_reg;
        freq_a_hi_next = freq_a_hi_reg;
        freq_b_hi_next = freq_b_hi_reg;
        ctrl_next = ctrl_reg;
        if (word_done)
        begin
            case (word[WADDR_HI:WADDR_LO])
                WADDR_CTRL:
                begin
                    ctrl_next = word[5:0];
                    freq_a_hi_next = 1'b0; // control write realigns halves
                    freq_b_hi_next = 1'b0;
                end
                WADDR_FREQ_A:
                begin
                    if (freq_a_hi_reg)
                        freq_a_next[ACC_W-1:HALF_W] = word[HALF_W-1:0];
                    else
                        freq_a_next[HALF_W-1:0] = word[HALF_W-1:0];
                    freq_a_hi_next = !freq_a_hi_reg;
                end
                WADDR_FREQ_B:
                begin
                    if (freq_b_hi_reg)
                        freq_b_next[ACC_W-1:HALF_W] = word[HALF_W-1:0];
                    else
                        freq_b_next[HALF_W-1:0] = word[HALF_W-1:0];
                    freq_b_hi_next = !freq_b_hi_reg;
                end
                WADDR_PHASE:
                    if (word[PHASE_SEL_POS])
                        phase_b_next = word[PHASE_W-1:0];
                    else
                        phase_a_next = word[PHASE_W-1:0];
                default:
                    ctrl_next = ctrl_reg;
            endcase
        end
    end

    // only rst clears these; datapath_reset never touches them
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            freq_a_reg <= 28'h000_0000;
            freq_b_reg <= 28'h000_0000;
            phase_a_reg <= 12'h000;
            phase_b_reg <= 12'h000;
            freq_a_hi_reg <= 1'b0;
            freq_b_hi_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            freq_a_reg <= freq_a_next;
            freq_b_reg <= freq_b_next;
            phase_a_reg <= phase_a_next;
            phase_b_reg <= phase_b_next;
            freq_a_hi_reg <= freq_a_hi_next;
            freq_b_hi_reg <= freq_b_hi_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // two-flop select synchronisers, switching lands on a clock edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            freq_select_bit_s1_reg <= 1'b0;
            freq_select_bit_s2_reg <= 1'b0;
            psel_s1_reg <= 1'b0;
            psel_s2_reg <= 1'b0;
        end
        else
        begin
            freq_select_bit_s1_reg <= freq_select_pin;
            freq_select_bit_s2_reg <= freq_select_bit_s1_reg;
            psel_s1_reg <= phase_select_pin;
            psel_s2_reg <= psel_s1_reg;
        end
    end

    // source of selection: pins when the pin-select bit is set
    assign use_b_freq = ctrl_reg[CTRL_PINSEL_POS] ? freq_select_bit_s2_reg
                        : ctrl_reg[CTRL_FREQ_SELECT_BIT_POS];
    assign use_b_phase = ctrl_reg[CTRL_PINSEL_POS] ? psel_s2_reg
                         : ctrl_reg[CTRL_PSEL_POS];

    // offset on accumulator msbs, then truncate to lookup address
    assign lut_addr = acc_reg[ACC_W-1 -: PHASE_W]
        + (use_b_phase ? phase_b_reg : phase_a_reg);

    // parabolic half-cycle shape stands in for a 4096-entry table,
    // trading a little harmonic purity for no memory
    always_comb
    begin
        prod = 32'(lut_addr[10:0]) * (32'h0000_0800 - 32'(lut_addr[10:0]));
        prod = prod * 32'(SINE_AMPL);
        mag = prod[28:20];
    end

    // accumulator, converter code and logic output
    always_comb
    begin
        // wraps modulo 2^28, so fout = word * fclk / 2^28
        acc_next = acc_reg + (use_b_freq ? freq_b_reg : freq_a_reg);
        dac_next = lut_addr[PHASE_W-1] ? DAC_MIDSCALE - 10'(mag)
                   : DAC_MIDSCALE + 10'(mag);
        if (datapath_reset)
        begin
            acc_next = 28'h000_0000;
            dac_next = DAC_MIDSCALE;
        end
        pdown_next = dac_powerdown_pin | ctrl_reg[CTRL_PDOWN_POS];
        sq_oe_n_next = !ctrl_reg[CTRL_OUTEN_POS];
        sq_next = ctrl_reg[CTRL_OUTSRC_POS] ? comparator_in
                  : acc_reg[ACC_W-1];
        if (!ctrl_reg[CTRL_OUTEN_POS])
            sq_next = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 28'h000_0000;
            dac_reg <= DAC_MIDSCALE;
            pdown_reg <= 1'b0;
            sq_reg <= 1'b0;
            sq_oe_n_reg <= 1'b1;
        end
        else
        begin
            acc_reg <= acc_next;
            dac_reg <= dac_next;
            pdown_reg <= pdown_next;
            sq_reg <= sq_next;
            sq_oe_n_reg <= sq_oe_n_next;
        end
    end

    assign dac_code = dac_reg;
    assign dac_powerdown = pdown_reg;
    assign square_out_pin = sq_reg;
    assign square_out_oe_n = sq_oe_n_reg;
endmodule : dds_core

/* tb/dds_link_properties.sv */
// wire checks on the serial link between host and dds core
// assumes host launches link pins from clk flops, two clks per sclk level
module dds_link_properties
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic frame_sync_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_q_reg;
    logic sclk_q_next;
    logic [5:0] fall_cnt_reg;
    logic [5:0] fall_cnt_next;

    // count sclk falls inside a frame; a high frame drops the count
    always_comb
    begin
        sclk_q_next = serial_clock_in;
        fall_cnt_next = fall_cnt_reg;
        if (frame_sync_n)
            fall_cnt_next = 6'h00;
        else if (sclk_q_reg && !serial_clock_in)
            fall_cnt_next = fall_cnt_reg + 6'h01;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_q_reg <= 1'b1;
            fall_cnt_reg <= 6'h00;
        end
        else
        begin
            sclk_q_reg <= sclk_q_next;
            fall_cnt_reg <= fall_cnt_next;
        end
    end

    property p_sclk_high_at_frame;
        @(posedge clk) disable iff (rst)
        $fell(frame_sync_n) |-> serial_clock_in;
    endproperty
    a_sclk_high_at_frame: assert property (p_sclk_high_at_frame)
        else $error("frame opened with serial clock low");

    property p_fall_in_frame;
        @(posedge clk) disable iff (rst)
        $fell(serial_clock_in) |-> !frame_sync_n;
    endproperty
    a_fall_in_frame: assert property (p_fall_in_frame)
        else $error("serial clock fell outside a frame");

    property p_data_at_fall;
        @(posedge clk) disable iff (rst)
        $fell(serial_clock_in) |-> $stable(serial_data_in) ##1
            $stable(serial_data_in);
    endproperty
    a_data_at_fall: assert property (p_data_at_fall)
        else $error("data moved around the sampling fall");

    property p_low_time;
        @(posedge clk) disable iff (rst)
        $fell(serial_clock_in) |-> !serial_clock_in[*2] ##1 serial_clock_in;
    endproperty
    a_low_time: assert property (p_low_time)
        else $error("serial clock low phase not two cycles");

    property p_word_len;
        @(posedge clk) disable iff (rst)
        $rose(frame_sync_n) |-> fall_cnt_reg[3:0] == 4'h0
            && fall_cnt_reg != 6'h00;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("frame closed off a sixteen bit boundary");

    property p_frame_time;
        @(posedge clk) disable iff (rst)
        $fell(frame_sync_n) |-> ##66 $rose(frame_sync_n);
    endproperty
    a_frame_time: assert property (p_frame_time)
        else $error("frame length differs from one word");
endmodule : dds_link_properties

/* tb/testbench.sv */
// self-checking bench: host and dds core joined by the link interface
// assumes software port as in dds_pkg, one 100 MHz clock for both ends
module testbench import dds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [31:0] val; logic [31:0] mask; } dds_note_t;
    localparam logic [31:0] M_DAC = 32'h1FF8;
    localparam logic [31:0] M_PD = 32'h4;
    localparam logic [31:0] M_SQ = 32'h3;
    dds_note_t notes[$];
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic freq_select_pin = 1'b0;
    logic phase_select_pin = 1'b0;
    logic datapath_reset = 1'b0;
    logic dac_powerdown_pin = 1'b0;
    logic comparator_in = 1'b0;
    logic [DAC_W-1:0] dac_code;
    logic dac_powerdown;
    logic square_out_pin;
    logic square_out_oe_n;
    logic rd_chk = 1'b0;
    logic rd_pend = 1'b0;
    logic [1:0] sel_chk = 2'h0;
    logic [31:0] meas = 32'h0;
    int n_fail = 0;
    int num_checks = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    dds_link_if dds_link_if_inst();
    dds_host dds_host_inst(.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .link(dds_link_if_inst));
    dds_core dds_core_inst(.clk, .rst, .link(dds_link_if_inst),
        .freq_select_pin, .phase_select_pin, .datapath_reset,
        .dac_powerdown_pin, .comparator_in, .dac_code, .dac_powerdown,
        .square_out_pin, .square_out_oe_n);
    dds_link_properties dds_link_properties_inst(.clk, .rst,
        .serial_clock_in(dds_link_if_inst.serial_clock_in),
        .serial_data_in(dds_link_if_inst.serial_data_in),
        .frame_sync_n(dds_link_if_inst.frame_sync_n));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic timeout;
        n_fail++;
        $display("ERROR %0t: wait ran out", $time);
        print_verdict();
    endtask : timeout

    // oldest note against the result showing this cycle
    always @(posedge clk)
    begin
        dds_note_t n;
        logic [31:0] obs;
        rd_pend <= rd_chk;
        if (rd_pend || sel_chk != 2'h0)
        begin
            n = notes.pop_front();
            obs = rd_pend ? rdata : (sel_chk == 2'h1) ? {19'h0, dac_code,
                dac_powerdown, square_out_pin, square_out_oe_n} : meas;
            num_checks++;
            if ((obs & n.mask) !== (n.val & n.mask))
            begin
                n_fail++;
                $display("ERROR %0t: got %h want %h", $time, obs, n.val);
            end
        end
    end

    task automatic chk(input logic [1:0] k, input logic [31:0] v,
        input logic [31:0] m);
        notes.push_back('{v, m});
        @(posedge clk);
        sel_chk <= k;
        @(posedge clk);
        sel_chk <= 2'h0;
    endtask : chk

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        notes.push_back('{e, 32'hFFFFFFFF});
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_chk <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        rd_chk <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    // one word out, then poll busy; a stuck host ends the run
    task automatic send(input logic [15:0] w);
        logic busy;
        int i;
        @(posedge clk);
        addr <= HOST_TX_ADDR;
        wdata <= {16'h0, w};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        busy = 1'b1;
        for (i = 0; i < 100 && busy !== 1'b0; i++)
        begin
            @(posedge clk);
            addr <= HOST_STAT_ADDR;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(posedge clk);
            busy = rdata[STAT_BUSY_POS];
        end
        if (busy !== 1'b0)
            timeout();
    endtask : send

    // rise to rise of the accumulator msb, free of pipeline latency
    task automatic period(input int e);
        logic prev;
        int n;
        int t0;
        prev = 1'b1;
        t0 = -1;
        for (n = 0; n < 400; n++)
        begin
            @(posedge clk);
            if (square_out_pin === 1'b1 && prev === 1'b0 && t0 >= 0)
                break;
            if (square_out_pin === 1'b1 && prev === 1'b0)
                t0 = n;
            prev = square_out_pin;
        end
        if (n == 400)
            timeout();
        meas = n - t0;
        chk(2'h2, e, 32'hFFFFFFFF);
    endtask : period

    // parabolic sine, sign from the top phase bit
    function automatic logic [9:0] sine_of(input logic [11:0] p);
        int x;
        int m;
        x = int'(p[10:0]);
        m = (x * (2048 - x) * 511) >>> 20;
        return p[11] ? 10'(512 - m) : 10'(512 + m);
    endfunction : sine_of

    initial
    begin
        logic [11:0] po [2];
        logic c;
        int i;
        void'($urandom(32'hD578));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk(2'h1, {19'h0, DAC_MIDSCALE, 3'b001}, 32'h1FFF);
        rd_reg(4'h8, 32'h0);
        rd_reg(HOST_STAT_ADDR, 32'h0);
        for (i = 0; i < 2; i++)
        begin
            po[i] = 12'($urandom);
            send({WADDR_PHASE, 1'b0, i[0], po[i]});
        end
        // frequency words still zero, so the dac shows the offset alone
        for (i = 0; i < 4; i++)
        begin
            phase_select_pin <= i[1] ? ~i[0] : i[0];
            send({WADDR_CTRL, 11'h0, ~i[1], i[0] & i[1], 1'b0});
            repeat (6) @(posedge clk);
            chk(2'h1, {19'h0, sine_of(po[i[0]]), 3'b0}, M_DAC);
        end
        datapath_reset <= 1'b1;
        repeat (2) @(posedge clk);
        chk(2'h1, {19'h0, DAC_MIDSCALE, 3'b0}, M_DAC);
        datapath_reset <= 1'b0;
        repeat (4) @(posedge clk);
        chk(2'h1, {19'h0, sine_of(po[1]), 3'b0}, M_DAC);
        send({WADDR_FREQ_A, 14'h0});
        send({WADDR_FREQ_A, 14'h80});
        send({WADDR_FREQ_B, 14'h0});
        send({WADDR_FREQ_B, 14'h100});
        // msb period is 2^28 over the word: 128 for a, 64 for b
        for (i = 0; i < 4; i++)
        begin
            freq_select_pin <= i[1] ? ~i[0] : i[0];
            send({WADDR_CTRL, 8'h0, 3'b010, ~i[1], 1'b0, i[0] & i[1]});
            repeat (6) @(posedge clk);
            period(i[0] ? 64 : 128);
        end
        // running accumulator: reset must pin msb and code at rest
        datapath_reset <= 1'b1;
        repeat (3) @(posedge clk);
        chk(2'h1, {19'h0, DAC_MIDSCALE, 3'b000}, M_DAC | M_SQ);
        datapath_reset <= 1'b0;
        period(64);
        send({WADDR_CTRL, 10'h0, 6'h34});
        for (i = 0; i < 4; i++)
        begin
            c = 1'($urandom);
            comparator_in <= c;
            repeat (3) @(posedge clk);
            chk(2'h1, {30'h0, c, 1'b0}, M_SQ);
        end
        send({WADDR_CTRL, 10'h0, 6'h24});
        comparator_in <= 1'b1;
        repeat (3) @(posedge clk);
        chk(2'h1, 32'h1, M_SQ);
        dac_powerdown_pin <= 1'b1;
        repeat (3) @(posedge clk);
        chk(2'h1, 32'h4, M_PD);
        dac_powerdown_pin <= 1'b0;
        send({WADDR_CTRL, 10'h0, 6'h0C});
        repeat (3) @(posedge clk);
        chk(2'h1, 32'h4, M_PD);
        send({WADDR_CTRL, 10'h0, 6'h04});
        repeat (3) @(posedge clk);
        chk(2'h1, 32'h0, M_PD);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule : testbench
